//--- bench/dbs_stage_model.sv
/*
 * Far-side model: the external brake command contact and the power stage
 * over-temperature flag, each answering after DLY extra cycles.
 * Assumes the bench gives the commands and a single clock with sync reset.
 */
`timescale 1ns/1ps
module dbs_stage_model #(
	parameter int DLY = 0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_cmd_i,
	input wire logic hot_cmd_i,
	output logic brake_req_o,
	output logic hot_o
);
	logic req_r [0:DLY];
	logic hot_r [0:DLY];

	// A delay line lets the source answer late, as a slow contact would.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i <= DLY; i++) begin
				req_r[i] <= 1'b0;
				hot_r[i] <= 1'b0;
			end
		end else begin
			req_r[0] <= req_cmd_i;
			hot_r[0] <= hot_cmd_i;
			for (int i = 1; i <= DLY; i++) begin
				req_r[i] <= req_r[i-1];
				hot_r[i] <= hot_r[i-1];
			end
		end
	end

	assign brake_req_o = req_r[DLY];
	assign hot_o = hot_r[DLY];
endmodule

//--- bench/testbench.sv
/*
 * Self-checking bench for the braking and start/stop sequencer.
 * Assumes the sequencer with short ticks (10 cycles) and slow steps (4).
 */
`timescale 1ns/1ps
module testbench
	import dbs_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_wdat = 32'h0;
	logic [31:0] wb_rdat;
	logic wb_ack;
	logic req_cmd = 1'b0;
	logic hot_cmd = 1'b0;
	logic brake_req;
	logic hot;
	logic [15:0] freq;
	logic out_en;
	logic dc_brake;
	logic [7:0] brake_cur;
	logic [7:0] carrier;
	logic carrier_red;
	logic [7:0] tone;
	int bad_count = 0;
	int n_compared = 0;
	int n;
	int m;
	logic [31:0] rd;
	logic [15:0] f_last;

	always #50 clk_i = ~clk_i;

	dbs_seq #(.TICK_CYC(10), .SLOW_CYC(4)) DUT (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.dc_brake_request_input_i(brake_req), .heatsink_hot_i(hot),
		.freq_o(freq), .out_en_o(out_en), .dc_brake_o(dc_brake),
		.brake_cur_o(brake_cur), .carrier_o(carrier),
		.carrier_reduced_o(carrier_red), .tone_o(tone));

	dbs_stage_model #(.DLY(0)) stage (.clk_i(clk_i), .rst_i(rst_i),
		.req_cmd_i(req_cmd), .hot_cmd_i(hot_cmd),
		.brake_req_o(brake_req), .hot_o(hot));

	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
	endtask

	// Holds the request until ack is sampled high at an edge.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int t;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_sel <= 4'h3;
		wb_wdat <= d;
		t = 0;
		// Waits as long as it takes; only the watchdog ends a lost answer.
		do begin
			@(posedge clk_i);
			t++;
		end while (wb_ack !== 1'b1);
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		// The slave answers one cycle after the edge that takes the request.
		chk("wb_ack_wait", t, 2);
	endtask

	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		tick(8000);
		chk("watchdog", 32'h1, 32'h0);
		end_of_test();
	end

	initial begin
		tick(4);
		rst_i <= 1'b0;
		tick(2);
		chk("carrier_o", carrier, 8'h08);
		chk("out_en_o", out_en, 1'b0);
		xfer(0, ADR_START_FREQ, 0);
		chk("start_freq", rd, 32'h64);
		xfer(1, 8'hfc, 32'h55);
		xfer(0, 8'hfc, 0);
		chk("unmapped", rd, 32'h0);
		xfer(1, ADR_CARRIER, 32'h1c);
		xfer(1, ADR_TONE, 32'h05);
		tick(3);
		chk("tone_o", tone, 8'h05);
		xfer(1, ADR_CARRIER, 32'h1d);
		tick(3);
		chk("tone_o", tone, 8'h00);
		xfer(1, ADR_CARRIER, 32'h20);
		hot_cmd <= 1'b1;
		tick(6);
		chk("carrier_o", carrier, 8'h10);
		chk("carrier_red", carrier_red, 1'b1);
		xfer(1, ADR_CTRL, 32'h4);
		tick(4);
		chk("carrier_o", carrier, 8'h20);
		chk("carrier_red", carrier_red, 1'b0);
		hot_cmd <= 1'b0;
		// Start below stop: no output until the reference passes stop.
		xfer(1, ADR_START_FREQ, 32'h32);
		xfer(1, ADR_START_HOLD, 32'h3);
		xfer(1, ADR_FREF, 32'h50);
		xfer(1, ADR_CTRL, 32'h1);
		tick(10);
		chk("out_en_o", out_en, 1'b0);
		xfer(1, ADR_FREF, 32'h200);
		tick(5);
		chk("out_en_o", out_en, 1'b1);
		chk("freq_o", freq, 16'h32);
		tick(10);
		chk("freq_o", freq, 16'h32);
		n = 15;
		while (freq === 16'h32 && n < 100) begin
			tick(1);
			n++;
		end
		chk("hold_long", n >= 20 && n <= 45, 1'b1);
		n = 0;
		while (freq !== 16'h200 && n < 300) begin
			tick(1);
			n++;
		end
		chk("freq_o", freq, 16'h200);
		xfer(0, ADR_FOUT, 0);
		chk("fout", rd, 32'h200);
		// Timed braking at quick response after run is removed.
		xfer(1, ADR_BRK_FREQ, 32'h96);
		xfer(1, ADR_BRK_LEVEL, 32'h28);
		xfer(1, ADR_BRK_DUR, 32'h4);
		xfer(1, ADR_CTRL, 32'h2);
		n = 0;
		f_last = freq;
		while (dc_brake !== 1'b1 && n < 300) begin
			if (freq !== 16'h0)
				f_last = freq;
			tick(1);
			n++;
		end
		chk("brake_at", f_last <= 16'h96 && f_last > 16'h32, 1'b1);
		tick(2);
		chk("brake_cur_o", brake_cur, 8'h28);
		n = 2;
		while (dc_brake === 1'b1 && n < 100) begin
			tick(1);
			n++;
		end
		chk("brake_len", n >= 30 && n <= 42, 1'b1);
		tick(3);
		chk("out_en_o", out_en, 1'b0);
		chk("brake_cur_o", brake_cur, 8'h00);
		xfer(0, ADR_STATUS, 0);
		chk("state", rd[2:0], 3'h0);
		// External request while stopped, slow build-up, clamped level.
		xfer(1, ADR_BRK_LEVEL, 32'h96);
		xfer(1, ADR_CTRL, 32'h0);
		req_cmd <= 1'b1;
		tick(5);
		chk("dc_brake_o", dc_brake, 1'b1);
		chk("slow_cur", brake_cur < 8'h03, 1'b1);
		tick(500);
		chk("dc_brake_o", dc_brake, 1'b1);
		chk("brake_cur_o", brake_cur, 8'h64);
		xfer(0, ADR_STATUS, 0);
		chk("state", rd[2:0], 3'h5);
		req_cmd <= 1'b0;
		tick(5);
		chk("dc_brake_o", dc_brake, 1'b0);
		chk("out_en_o", out_en, 1'b0);
		// Zero duration: reference drop ends in a stop hold, no braking.
		xfer(1, ADR_BRK_DUR, 32'h0);
		xfer(1, ADR_STOP_HOLD, 32'h2);
		xfer(1, ADR_START_HOLD, 32'h0);
		xfer(1, ADR_FREF, 32'h12c);
		xfer(1, ADR_CTRL, 32'h1);
		n = 0;
		while (freq !== 16'h12c && n < 300) begin
			tick(1);
			n++;
		end
		chk("freq_o", freq, 16'h12c);
		xfer(1, ADR_FREF, 32'h0);
		n = 0;
		m = 0;
		while (out_en === 1'b1 && n < 300) begin
			chk("dc_brake_o", dc_brake, 1'b0);
			if (freq === 16'h64)
				m++;
			tick(1);
			n++;
		end
		chk("dc_brake_o", dc_brake, 1'b0);
		chk("stop_hold", m >= 10 && m <= 32, 1'b1);
		chk("out_en_o", out_en, 1'b0);
		end_of_test();
	end
endmodule

//--- logic/dbs_brake_ramp.sv
/*
 * Braking current build-up: follows the braking level either at once or
 * one percent at a time, clamped to rated current.
 * Assumes the caller holds active_i high for the whole braking period.
 */
`timescale 1ns/1ps
module dbs_brake_ramp
	import dbs_pkg::*;
#(
	parameter int SLOW_CYC = SLOW_STEP_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic active_i,
	input wire logic quick_i,
	input wire logic [7:0] level_i,
	output logic [7:0] cur_o
);

	logic [7:0] lvl;
	logic [15:0] cnt_r;

	// Levels above rated current are clamped rather than honoured.
	assign lvl = (level_i > LEVEL_FULL) ? LEVEL_FULL : level_i;

	always_ff @(posedge clk_i) begin
		if (rst_i || !active_i) begin
			cur_o <= 8'h00;
			cnt_r <= 16'h0000;
		end else if (quick_i || cur_o > lvl) begin
			cur_o <= lvl;
			cnt_r <= 16'h0000;
		end else if (cur_o < lvl) begin
			if (cnt_r >= 16'(SLOW_CYC - 1)) begin
				cur_o <= cur_o + 8'h01;
				cnt_r <= 16'h0000;
			end else begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end
	end

endmodule

//--- logic/dbs_pkg.sv
/*
 * Package for the DC braking and start/stop sequencer: register offsets,
 * field positions, reset values, timing counts, the state enumeration and
 * the packed settings carrier.
 * Assumes a 10 MHz system clock and a classic Wishbone register bus.
 */
// Function
// - Stopping, DC braking starts once output falls to the brake frequency.
// - Braking level is in 1 percent steps of rated current, 100 being rated.
// - Once DC braking starts, it lasts the braking duration and then ends.
// - With response select 0, braking current rises slowly at braking onset.
// - With response select 1, braking current rises fast at braking onset.
// - Braking holds while the brake request is high, whatever the duration.
// - A brake request while stopped starts braking to pre-excite the motor.
// - On a start, the first output frequency equals the starting frequency.
// - When output frequency falls to stop frequency, drive output ceases.
// - After a start, the starting frequency is held for start hold time.
// - Stop frequency is held for stop hold time before the output ends.
// - If start is below stop frequency, no output until reference tops it.
// - Hot at high carrier, the carrier drops unless the option disables it.
// - Tone acts only while the carrier setting is 7 kHz or lower.
// - A braking duration of zero disables timed DC braking altogether.
// - Timed braking follows run removal or a reference drop below stop.
package dbs_pkg;

	localparam int CLK_PERIOD_NS = 100;
	// One setting unit of every time register is 0.01 s.
	localparam int TICK_NS = 10_000_000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	// Least time between two one-percent steps of the slow braking build-up.
	localparam int SLOW_STEP_NS = 100_000;
	localparam int SLOW_STEP_CYCLES =
		(SLOW_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [7:0] LEVEL_FULL = 8'h64;
	// Carrier setting is in 0.25 kHz units; 7 kHz is 28 units.
	localparam logic [7:0] CARRIER_TONE_MAX = 8'h1c;
	localparam logic [7:0] CARRIER_REDUCED = 8'h10;

	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_FREF = 8'h04;
	localparam logic [7:0] ADR_BRK_FREQ = 8'h08;
	localparam logic [7:0] ADR_BRK_LEVEL = 8'h0c;
	localparam logic [7:0] ADR_BRK_DUR = 8'h10;
	localparam logic [7:0] ADR_START_FREQ = 8'h14;
	localparam logic [7:0] ADR_START_HOLD = 8'h18;
	localparam logic [7:0] ADR_STOP_FREQ = 8'h1c;
	localparam logic [7:0] ADR_STOP_HOLD = 8'h20;
	localparam logic [7:0] ADR_CARRIER = 8'h24;
	localparam logic [7:0] ADR_TONE = 8'h28;
	localparam logic [7:0] ADR_ACCEL = 8'h2c;
	localparam logic [7:0] ADR_STATUS = 8'h30;
	localparam logic [7:0] ADR_FOUT = 8'h34;

	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_RESP_BIT = 1;
	localparam int CTRL_NORED_BIT = 2;
	localparam int STAT_OUT_EN_BIT = 3;
	localparam int STAT_DCB_BIT = 4;
	localparam int STAT_RED_BIT = 5;

	typedef enum {
		ST_STOP,
		ST_START_HOLD,
		ST_RUN,
		ST_STOP_HOLD,
		ST_DCB_TIMED,
		ST_DCB_EXT
	} dbs_state_t;

	typedef struct packed {
		logic run;
		logic braking_response_select;
		logic protection_option_setting;
		logic [15:0] fref;
		logic [15:0] braking_start_freq_setting;
		logic [7:0] braking_current_level;
		logic [15:0] braking_duration;
		logic [15:0] start_freq_setting;
		logic [15:0] start_hold_time;
		logic [15:0] stop_freq_setting;
		logic [15:0] stop_hold_time;
		logic [7:0] carrier_freq_setting;
		logic [7:0] tone_setting;
		logic [15:0] accel_step;
	} dbs_cfg_t;

	localparam dbs_cfg_t CFG_RST = '{
		run: 1'b0,
		braking_response_select: 1'b0,
		protection_option_setting: 1'b0,
		fref: 16'h0000,
		braking_start_freq_setting: 16'h0000,
		braking_current_level: 8'h00,
		braking_duration: 16'h0000,
		start_freq_setting: 16'h0064,
		start_hold_time: 16'h0000,
		stop_freq_setting: 16'h0064,
		stop_hold_time: 16'h0000,
		carrier_freq_setting: 8'h08,
		tone_setting: 8'h00,
		accel_step: 16'h0064
	};

endpackage

//--- logic/dbs_seq.sv
/*
 * Start/stop sequencer with DC injection braking, carrier reduction and
 * tone gating, reached over a classic Wishbone slave.
 * Assumes synchronous inputs, 10 MHz clk_i and a synchronous reset.
 */
`timescale 1ns/1ps
module dbs_seq
	import dbs_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES,
	parameter int SLOW_CYC = SLOW_STEP_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic dc_brake_request_input_i,
	input wire logic heatsink_hot_i,
	output logic [15:0] freq_o,
	output logic out_en_o,
	output logic dc_brake_o,
	output logic [7:0] brake_cur_o,
	output logic [7:0] carrier_o,
	output logic carrier_reduced_o,
	output logic [7:0] tone_o
);

	dbs_cfg_t cfg_r;
	dbs_state_t state_r;
	logic [15:0] fout_r;
	logic [15:0] timer_r;
	logic [31:0] tick_cnt_r;
	logic tick_r;
	logic bus_req;
	logic bus_wr;
	logic run_eff;
	logic ext;
	logic dcb_act;
	logic [15:0] tgt;
	logic [31:0] rd_data;

	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr = bus_req && wb_we_i;
	assign ext = dc_brake_request_input_i;
	// Run stays in force only while the reference is above stop frequency,
	// which also keeps a low starting frequency from producing output.
	assign run_eff = cfg_r.run &&
		(cfg_r.fref > cfg_r.stop_freq_setting);
	assign tgt = run_eff ? cfg_r.fref : 16'h0000;
	assign dcb_act = (state_r == ST_DCB_TIMED) || (state_r == ST_DCB_EXT);

	function automatic logic [15:0] wr16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0])
			r[7:0] = d[7:0];
		if (sel[1])
			r[15:8] = d[15:8];
		return r;
	endfunction

	function automatic logic [15:0] step_to(input logic [15:0] cur,
		input logic [15:0] goal, input logic [15:0] stp);
		logic [16:0] s;
		s = {1'b0, cur} + {1'b0, stp};
		if (cur < goal)
			return (s > {1'b0, goal}) ? goal : s[15:0];
		else if (cur - goal > stp)
			return cur - stp;
		else
			return goal;
	endfunction

	// Bus slave: one wait state, ack for one cycle, unmapped reads give 0.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i)
				wb_dat_o <= rd_data;
		end
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		case (wb_adr_i)
			ADR_CTRL: begin
				rd_data[CTRL_RUN_BIT] = cfg_r.run;
				rd_data[CTRL_RESP_BIT] = cfg_r.braking_response_select;
				rd_data[CTRL_NORED_BIT] = cfg_r.protection_option_setting;
			end
			ADR_FREF: rd_data[15:0] = cfg_r.fref;
			ADR_BRK_FREQ: rd_data[15:0] = cfg_r.braking_start_freq_setting;
			ADR_BRK_LEVEL: rd_data[7:0] = cfg_r.braking_current_level;
			ADR_BRK_DUR: rd_data[15:0] = cfg_r.braking_duration;
			ADR_START_FREQ: rd_data[15:0] = cfg_r.start_freq_setting;
			ADR_START_HOLD: rd_data[15:0] = cfg_r.start_hold_time;
			ADR_STOP_FREQ: rd_data[15:0] = cfg_r.stop_freq_setting;
			ADR_STOP_HOLD: rd_data[15:0] = cfg_r.stop_hold_time;
			ADR_CARRIER: rd_data[7:0] = cfg_r.carrier_freq_setting;
			ADR_TONE: rd_data[7:0] = cfg_r.tone_setting;
			ADR_ACCEL: rd_data[15:0] = cfg_r.accel_step;
			ADR_STATUS: begin
				rd_data[2:0] = 3'(state_r);
				rd_data[STAT_OUT_EN_BIT] = out_en_o;
				rd_data[STAT_DCB_BIT] = dc_brake_o;
				rd_data[STAT_RED_BIT] = carrier_reduced_o;
				rd_data[15:8] = brake_cur_o;
				rd_data[23:16] = carrier_o;
			end
			ADR_FOUT: rd_data[15:0] = fout_r;
			default: rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_r <= CFG_RST;
		end else if (bus_wr) begin
			case (wb_adr_i)
				ADR_CTRL: begin
					if (wb_sel_i[0]) begin
						cfg_r.run <= wb_dat_i[CTRL_RUN_BIT];
						cfg_r.braking_response_select <=
							wb_dat_i[CTRL_RESP_BIT];
						cfg_r.protection_option_setting <=
							wb_dat_i[CTRL_NORED_BIT];
					end
				end
				ADR_FREF: cfg_r.fref <= wr16(cfg_r.fref, wb_dat_i, wb_sel_i);
				ADR_BRK_FREQ: cfg_r.braking_start_freq_setting <=
					wr16(cfg_r.braking_start_freq_setting, wb_dat_i,
					wb_sel_i);
				ADR_BRK_LEVEL: begin
					if (wb_sel_i[0])
						cfg_r.braking_current_level <= wb_dat_i[7:0];
				end
				ADR_BRK_DUR: cfg_r.braking_duration <=
					wr16(cfg_r.braking_duration, wb_dat_i, wb_sel_i);
				ADR_START_FREQ: cfg_r.start_freq_setting <=
					wr16(cfg_r.start_freq_setting, wb_dat_i, wb_sel_i);
				ADR_START_HOLD: cfg_r.start_hold_time <=
					wr16(cfg_r.start_hold_time, wb_dat_i, wb_sel_i);
				ADR_STOP_FREQ: cfg_r.stop_freq_setting <=
					wr16(cfg_r.stop_freq_setting, wb_dat_i, wb_sel_i);
				ADR_STOP_HOLD: cfg_r.stop_hold_time <=
					wr16(cfg_r.stop_hold_time, wb_dat_i, wb_sel_i);
				ADR_CARRIER: begin
					if (wb_sel_i[0])
						cfg_r.carrier_freq_setting <= wb_dat_i[7:0];
				end
				ADR_TONE: begin
					if (wb_sel_i[0])
						cfg_r.tone_setting <= wb_dat_i[7:0];
				end
				ADR_ACCEL: cfg_r.accel_step <=
					wr16(cfg_r.accel_step, wb_dat_i, wb_sel_i);
				default: cfg_r <= cfg_r;
			endcase
		end
	end

	// The 0.01 s time base is free running, so a hold may end up to one
	// tick early; a finer base would cost a wider timer for no real gain.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_r <= 32'h0000_0000;
			tick_r <= 1'b0;
		end else if (tick_cnt_r >= 32'(TICK_CYC - 1)) begin
			tick_cnt_r <= 32'h0000_0000;
			tick_r <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
			tick_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= ST_STOP;
			fout_r <= 16'h0000;
			timer_r <= 16'h0000;
		end else begin
			if (tick_r && timer_r != 16'h0000)
				timer_r <= timer_r - 16'h0001;
			case (state_r)
				ST_STOP: begin
					fout_r <= 16'h0000;
					if (ext) begin
						state_r <= ST_DCB_EXT;
					end else if (run_eff) begin
						fout_r <= cfg_r.start_freq_setting;
						timer_r <= cfg_r.start_hold_time;
						state_r <= ST_START_HOLD;
					end
				end
				ST_START_HOLD: begin
					if (ext) begin
						fout_r <= 16'h0000;
						state_r <= ST_DCB_EXT;
					end else if (timer_r == 16'h0000 || !run_eff) begin
						state_r <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (ext) begin
						fout_r <= 16'h0000;
						state_r <= ST_DCB_EXT;
					end else if (!run_eff &&
						cfg_r.braking_duration != 16'h0000 &&
						fout_r <= cfg_r.braking_start_freq_setting) begin
						fout_r <= 16'h0000;
						timer_r <= cfg_r.braking_duration;
						state_r <= ST_DCB_TIMED;
					end else if (!run_eff &&
						fout_r <= cfg_r.stop_freq_setting) begin
						fout_r <= cfg_r.stop_freq_setting;
						timer_r <= cfg_r.stop_hold_time;
						state_r <= ST_STOP_HOLD;
					end else if (tick_r) begin
						fout_r <= step_to(fout_r, tgt, cfg_r.accel_step);
					end
				end
				ST_STOP_HOLD: begin
					if (ext) begin
						fout_r <= 16'h0000;
						state_r <= ST_DCB_EXT;
					end else if (run_eff) begin
						state_r <= ST_RUN;
					end else if (timer_r == 16'h0000) begin
						fout_r <= 16'h0000;
						state_r <= ST_STOP;
					end
				end
				ST_DCB_TIMED: begin
					if (ext)
						state_r <= ST_DCB_EXT;
					else if (timer_r == 16'h0000)
						state_r <= ST_STOP;
				end
				ST_DCB_EXT: begin
					if (!ext && run_eff) begin
						fout_r <= cfg_r.start_freq_setting;
						timer_r <= cfg_r.start_hold_time;
						state_r <= ST_START_HOLD;
					end else if (!ext) begin
						state_r <= ST_STOP;
					end
				end
				default: begin
					fout_r <= 16'h0000;
					state_r <= ST_STOP;
				end
			endcase
		end
	end

	// Drive outputs lag the state by one cycle so that they come from flops.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			freq_o <= 16'h0000;
			out_en_o <= 1'b0;
			dc_brake_o <= 1'b0;
		end else begin
			freq_o <= fout_r;
			out_en_o <= (state_r == ST_START_HOLD) ||
				(state_r == ST_RUN) || (state_r == ST_STOP_HOLD);
			dc_brake_o <= dcb_act;
		end
	end

	dbs_brake_ramp #(
		.SLOW_CYC(SLOW_CYC)
	) u_ramp (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.active_i(dcb_act),
		.quick_i(cfg_r.braking_response_select),
		.level_i(cfg_r.braking_current_level),
		.cur_o(brake_cur_o)
	);

	// Reduction only drops to a fixed safe carrier; it does not track heat.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			carrier_o <= CFG_RST.carrier_freq_setting;
			carrier_reduced_o <= 1'b0;
			tone_o <= 8'h00;
		end else begin
			if (heatsink_hot_i && !cfg_r.protection_option_setting &&
				cfg_r.carrier_freq_setting > CARRIER_REDUCED) begin
				carrier_o <= CARRIER_REDUCED;
				carrier_reduced_o <= 1'b1;
			end else begin
				carrier_o <= cfg_r.carrier_freq_setting;
				carrier_reduced_o <= 1'b0;
			end
			if (cfg_r.carrier_freq_setting <= CARRIER_TONE_MAX)
				tone_o <= cfg_r.tone_setting;
			else
				tone_o <= 8'h00;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_decel_at_brk;
		state_r == ST_RUN && !ext && !run_eff &&
		cfg_r.braking_duration != 16'h0000 &&
		fout_r <= cfg_r.braking_start_freq_setting;
	endsequence

	sequence s_timed_brk_out;
		state_r == ST_DCB_TIMED ##1 dc_brake_o;
	endsequence

	a_brk_start_freq: assert property (
		s_decel_at_brk |=> s_timed_brk_out)
		else $error("braking did not start at braking frequency");

	a_brk_level_cap: assert property (
		brake_cur_o <= LEVEL_FULL)
		else $error("braking current above rated level");

	a_brk_timed_end: assert property (
		state_r == ST_DCB_TIMED && timer_r == 16'h0000 && !ext
		|=> state_r == ST_STOP ##1 !dc_brake_o && !out_en_o)
		else $error("timed braking did not end");

	a_slow_rise: assert property (
		dcb_act && !cfg_r.braking_response_select &&
		brake_cur_o > $past(brake_cur_o) && $stable(
		cfg_r.braking_current_level) && SLOW_CYC > 1
		|-> brake_cur_o == $past(brake_cur_o) + 8'h01 ##1
		$stable(brake_cur_o))
		else $error("slow braking build-up stepped too fast");

	a_quick_rise: assert property (
		dcb_act && cfg_r.braking_response_select &&
		cfg_r.braking_current_level <= LEVEL_FULL ##1
		dcb_act && $stable(cfg_r.braking_current_level)
		|-> brake_cur_o == cfg_r.braking_current_level)
		else $error("quick braking build-up missed level");

	a_ext_brk_held: assert property (
		dcb_act && ext |=> state_r == ST_DCB_EXT)
		else $error("external brake request not honoured");

	a_ext_from_stop: assert property (
		state_r == ST_STOP && ext |=> state_r == ST_DCB_EXT ##1
		dc_brake_o)
		else $error("stopped drive did not brake on request");

	a_start_freq: assert property (
		state_r == ST_STOP && !ext && run_eff |=>
		state_r == ST_START_HOLD &&
		fout_r == $past(cfg_r.start_freq_setting) ##1 out_en_o)
		else $error("start did not use starting frequency");

	a_no_low_output: assert property (
		state_r == ST_STOP && cfg_r.fref <= cfg_r.stop_freq_setting
		|=> state_r != ST_START_HOLD)
		else $error("output started below stop frequency");

	a_carrier_cut: assert property (
		heatsink_hot_i && !cfg_r.protection_option_setting &&
		cfg_r.carrier_freq_setting > CARRIER_REDUCED
		|=> carrier_o == CARRIER_REDUCED && carrier_reduced_o)
		else $error("carrier not reduced under heat");

	a_tone_gate: assert property (
		cfg_r.carrier_freq_setting > CARRIER_TONE_MAX |=> tone_o == 8'h00)
		else $error("tone applied above carrier limit");

	a_zero_dur_off: assert property (
		state_r != ST_DCB_TIMED &&
		cfg_r.braking_duration == 16'h0000 && !ext
		|=> state_r != ST_DCB_TIMED)
		else $error("timed braking with zero duration");

endmodule
